// [design/cpm_fix_div.sv]
// fixed clock divider producing a one-cycle enable every DIV source cycles
// assumes clk_i is the common source clock and rst_n_i the synced reset
module cpm_fix_div #(
  parameter int unsigned DIV = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      en_o
);
  localparam int unsigned CW = $clog2(DIV);

  // ====================================================================
  // elaboration check
  if (DIV < 2 || (DIV & (DIV - 1)) != 0) begin : g_chk
    $error("cpm_fix_div: DIV must be a power of two of at least 2");
  end

  // ====================================================================
  // counter
  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign en_o = (cnt_q == CW'(DIV - 1));

  a_fix_spacing: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE9]
    en_o |=> !en_o ##0 (cnt_q == '0))
    else $error("fixed divider enable not spaced by the ratio");
endmodule

// [design/cpm_sel_div.sv]
// selectable power-of-two divider producing a one-cycle enable
// assumes sel_i may change at any time; it is taken only at a period end
module cpm_sel_div #(
  parameter int unsigned SEL_W = 3
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [SEL_W-1:0] sel_i,
  output logic                  en_o
);
  localparam int unsigned CW = (1 << SEL_W) - 1;

  // ====================================================================
  // elaboration check
  if (SEL_W < 1 || SEL_W > 4) begin : g_chk
    $error("cpm_sel_div: SEL_W must lie in 1 to 4");
  end

  // ====================================================================
  // counter; ratio 2**sel, ratio latched only at a period end so that
  // no shortened period is ever produced
  logic [CW-1:0]    cnt_q;
  logic [SEL_W-1:0] sel_q;
  logic [CW-1:0]    lim_w;

  assign lim_w = CW'((32'h0000_0001 << sel_q) - 32'h0000_0001);
  assign en_o  = (cnt_q == lim_w);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      sel_q <= '0;
    end else if (en_o) begin
      cnt_q <= '0;
      sel_q <= sel_i; // [RULE11]
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  a_sel_clean: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE11]
    !en_o |=> $stable(sel_q))
    else $error("divider ratio changed inside a period");

  a_sel_period: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE11]
    en_o |=> (cnt_q == '0) && (sel_q == $past(sel_i)))
    else $error("divider did not restart with the new ratio");
endmodule

// [design/cpm_top.sv]
// clock, power and low-power mode control with apb registers
// assumes all inputs synchronous to sys_clk_i; analog comparators and
// supervisors deliver plain levels
//
// The APB interface to the registers and the register addresses were decided locally.
module cpm_top
  import cpm_pkg::*;
#(
  parameter int unsigned NPIN      = 8,
  parameter int unsigned LPM4_WAKE = LPM4_WAKE_CYC,
  parameter int unsigned BOR_MAX   = WAKE_MAX_CYC
) (
  input  wire logic            sys_clk_i,
  input  wire logic            rst_n_i,
  input  wire cpm_apb_req_t    apb_i,
  output logic [31:0]          prdata_o,
  output logic                 pready_o,
  output logic                 pslverr_o,
  input  wire logic            supply_domain_reset_ind_i,
  input  wire logic            core_supply_supervisor_i,
  input  wire logic            monitor_input_pin_low_i,
  input  wire logic            digital_supply_low_i,
  input  wire logic            nmi_pin_n_i,
  input  wire logic            wake_pin_irq_i,
  input  wire logic            wake_event_i,
  input  wire logic [NPIN-1:0] pin_direction_i,
  input  wire logic [NPIN-1:0] pin_output_i,
  output logic                 brownout_reset_o,
  output logic                 core_regulator_en_o,
  output logic                 osc_enable_o,
  output logic                 ext_clk_sel_o,
  output cpm_clk_en_t          clk_en_o,
  output logic [2:0]           voltage_monitor_level_o,
  output logic                 voltage_monitor_irq_o,
  output logic [15:0]          reset_vector_o,
  output logic [2:0]           lpm_mode_o,
  output logic [NPIN-1:0]      pad_dir_o,
  output logic [NPIN-1:0]      pad_out_o
);

  // ====================================================================
  // elaboration checks
  if (NPIN < 1 || NPIN > 32) begin : g_chk_pin
    $error("cpm_top: NPIN must lie in 1 to 32");
  end
  if (LPM4_WAKE < 1 || LPM4_WAKE > 65535) begin : g_chk_wake
    $error("cpm_top: LPM4_WAKE must lie in 1 to 65535");
  end
  // the release delay must fit inside the brown-out recovery budget
  if (REL_CYC > BOR_MAX) begin : g_chk_bor // [RULE13]
    $error("cpm_top: release delay exceeds brown-out recovery budget");
  end

  // ====================================================================
  // reset synchroniser
  logic rst_s1_q;
  logic rst_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_q    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q    <= rst_s1_q;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_q);

  // ====================================================================
  // apb decode; zero wait states, read data captured in setup cycle
  logic        acc_w;
  logic        wr_w;
  logic        hit_w;
  logic [31:0] rd_w;
  logic [31:0] prdata_q;

  assign acc_w = apb_i.psel && apb_i.penable;
  assign wr_w  = acc_w && apb_i.pwrite && hit_w;
  assign hit_w = (apb_i.paddr == OFS_CLK) || (apb_i.paddr == OFS_VOLTAGE_MONITOR) ||
                 (apb_i.paddr == OFS_STAT) || (apb_i.paddr == OFS_LPM) ||
                 (apb_i.paddr == OFS_SDC) || (apb_i.paddr == OFS_CAL);

  assign pready_o  = 1'b1;
  assign pslverr_o = acc_w && !hit_w;
  assign prdata_o  = prdata_q;

  // ====================================================================
  // registers
  cpm_state_t  state_q;
  cpm_state_t  state_d;
  logic [15:0] cnt_q;
  logic        bor_q;
  logic [6:0]  clk_q;
  logic [4:0]  vm_q;
  logic        vm_flag_q;
  logic        pwr_flag_q;
  logic        lock_q;
  logic        deep_wake_q;
  logic [15:0] cal_q;
  logic [2:0]  mode_q;
  logic        nmi_prev_q;
  logic        nmi_fall_w;
  logic        lpm_wr_w;
  logic        off_exit_w;
  logic [15:0] wake_lim_w;
  logic        vm_low_w;

  assign lpm_wr_w   = wr_w && (apb_i.paddr == OFS_LPM) &&
                      (apb_i.pwdata[2:0] <= MODE_DEEP); // [RULE12]
  assign nmi_fall_w = nmi_prev_q && !nmi_pin_n_i;
  assign off_exit_w = (state_q == ST_OFF) && (state_d != ST_OFF);

  // clock and voltage monitor fields fall back to reset values during brownout reset
  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      clk_q <= CLK_RST;
      vm_q  <= VM_RST;
    end else if (bor_q) begin
      clk_q <= CLK_RST;
      vm_q  <= VM_RST; // [RULE7]
    end else if (wr_w && apb_i.paddr == OFS_CLK) begin
      clk_q <= apb_i.pwdata[6:0];
    end else if (wr_w && apb_i.paddr == OFS_VOLTAGE_MONITOR) begin
      vm_q <= apb_i.pwdata[4:0];
    end
  end

  // calibration survives every reset but a power cycle
  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      cal_q <= CAL_RST;
    end else if (supply_domain_reset_ind_i) begin
      cal_q <= CAL_RST; // [RULE22]
    end else if (wr_w && apb_i.paddr == OFS_CAL) begin
      cal_q <= apb_i.pwdata[15:0];
    end
  end

  // power-cycle flag: set by power-on or a supply domain reset only;
  // a set arriving with the clear wins
  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      pwr_flag_q <= 1'b1;
    end else if (supply_domain_reset_ind_i) begin
      pwr_flag_q <= 1'b1; // [RULE4] [RULE22]
    end else if (wr_w && apb_i.paddr == OFS_STAT && apb_i.pwdata[ST_PWR_BIT]) begin
      pwr_flag_q <= 1'b0;
    end
  end

  // ====================================================================
  // voltage monitor
  assign vm_low_w = vm_q[VM_SRC_BIT] ? digital_supply_low_i
                                     : monitor_input_pin_low_i;

  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      vm_flag_q <= 1'b0;
    end else if (bor_q) begin
      vm_flag_q <= 1'b0;
    end else if (vm_q[VM_EN_BIT] && vm_low_w) begin
      vm_flag_q <= 1'b1; // [RULE6]
    end else if (wr_w && apb_i.paddr == OFS_STAT && apb_i.pwdata[ST_VM_BIT]) begin
      vm_flag_q <= 1'b0;
    end
  end

  assign voltage_monitor_level_o = vm_q[VM_LVL_LSB +: 3];
  assign voltage_monitor_irq_o   = vm_flag_q && vm_q[VM_EN_BIT]; // [RULE6] [RULE7]

  // ====================================================================
  // reset and mode sequencer
  always_comb begin
    case (mode_q)
      MODE_LPM3: wake_lim_w = 16'(LPM3_WAKE_CYC - 1); // [RULE13]
      MODE_LPM4: wake_lim_w = 16'(LPM4_WAKE - 1); // [RULE13]
      default:   wake_lim_w = 16'h0000;
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        if (!supply_domain_reset_ind_i && !core_supply_supervisor_i) begin
          state_d = ST_DELAY; // [RULE1]
        end
      end
      ST_DELAY: begin
        if (cnt_q == 16'(REL_CYC - 1)) begin
          state_d = ST_RUN; // [RULE2]
        end
      end
      ST_RUN: begin
        if (lpm_wr_w) begin
          state_d = (apb_i.pwdata[2:0] == MODE_DEEP) ? ST_OFF : ST_LPM; // [RULE12]
        end
      end
      ST_LPM: begin
        if (wake_event_i) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (cnt_q == wake_lim_w) begin
          state_d = ST_RUN;
        end
      end
      ST_OFF: begin
        if (nmi_fall_w || wake_pin_irq_i) begin
          state_d = ST_HOLD; // [RULE15] [RULE16]
        end
      end
      default: state_d = ST_HOLD;
    endcase
    // the core supervisor naturally reports reset while the regulator is off
    if (supply_domain_reset_ind_i ||
        (core_supply_supervisor_i && state_q != ST_OFF)) begin
      state_d = ST_HOLD; // [RULE3] [RULE4] [RULE5] [RULE15]
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      state_q    <= ST_HOLD;
      cnt_q      <= 16'h0000;
      bor_q      <= 1'b1;
      nmi_prev_q <= 1'b1;
    end else begin
      state_q    <= state_d;
      cnt_q      <= (state_d != state_q) ? 16'h0000 : cnt_q + 16'h0001;
      bor_q      <= (state_d == ST_HOLD) || (state_d == ST_DELAY) ||
                    (state_d == ST_OFF); // [RULE1] [RULE16]
      nmi_prev_q <= nmi_pin_n_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      mode_q <= 3'h0;
    end else if (state_q == ST_RUN && lpm_wr_w) begin
      mode_q <= apb_i.pwdata[2:0];
    end
  end

  assign brownout_reset_o = bor_q;
  assign reset_vector_o   = RESET_VECTOR; // [RULE16]
  assign lpm_mode_o       = mode_q;

  // ====================================================================
  // pin lock; lives across brownout reset, lost only on power-on or an SDC write with the lock bit low
  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      lock_q <= 1'b0;
    end else if (state_q == ST_RUN && state_d == ST_OFF) begin
      lock_q <= 1'b1; // [RULE17]
    end else if (wr_w && apb_i.paddr == OFS_SDC && !apb_i.pwdata[SD_LOCK_BIT]) begin
      lock_q <= 1'b0; // [RULE19]
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      deep_wake_q <= 1'b0;
    end else if (off_exit_w) begin
      deep_wake_q <= 1'b1;
    end else if (wr_w && apb_i.paddr == OFS_SDC && apb_i.pwdata[SD_WAKE_BIT]) begin
      deep_wake_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      pad_dir_o <= '0;
      pad_out_o <= '0;
    end else if (!lock_q) begin
      pad_dir_o <= pin_direction_i; // [RULE17] [RULE18]
      pad_out_o <= pin_output_i;
    end
  end

  // ====================================================================
  // clock generation
  logic sel_cpu_w;
  logic sel_sub_w;
  logic fix_aux_w;
  logic fix_mod_w;
  logic asleep_w;
  logic off_w;
  logic deep4_w;

  cpm_sel_div #(.SEL_W(3)) u_cpu_div ( // [RULE10]
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_q),
    .sel_i   (clk_q[CPU_DIV_LSB +: 3]),
    .en_o    (sel_cpu_w)
  );

  cpm_sel_div #(.SEL_W(3)) u_sub_div ( // [RULE10]
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_q),
    .sel_i   (clk_q[SUB_DIV_LSB +: 3]),
    .en_o    (sel_sub_w)
  );

  cpm_fix_div #(.DIV(AUX_DIV)) u_aux_div ( // [RULE9]
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_q),
    .en_o    (fix_aux_w)
  );

  cpm_fix_div #(.DIV(MOD_DIV)) u_mod_div ( // [RULE9]
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_q),
    .en_o    (fix_mod_w)
  );

  assign asleep_w = (state_q == ST_LPM) || (state_q == ST_WAKE);
  assign off_w    = (state_q == ST_OFF);
  assign deep4_w  = asleep_w && (mode_q == MODE_LPM4);

  // gating per low-power mode; clocks stay off until the wake latency ends
  assign clk_en_o.cpu = sel_cpu_w && !asleep_w && !off_w; // [RULE12]
  assign clk_en_o.sub = sel_sub_w && !off_w && !(asleep_w && mode_q >= MODE_LPM2);
  assign clk_en_o.aux = fix_aux_w && !off_w && !deep4_w;
  assign clk_en_o.mdm = fix_mod_w && !off_w && !deep4_w;

  assign ext_clk_sel_o       = clk_q[CLK_EXT_BIT];
  assign osc_enable_o        = !clk_q[CLK_EXT_BIT] && !off_w && !deep4_w; // [RULE8]
  assign core_regulator_en_o = !off_w; // [RULE14]

  // ====================================================================
  // read data
  always_comb begin
    rd_w = 32'h0000_0000;
    case (apb_i.paddr)
      OFS_CLK:  rd_w[6:0] = clk_q;
      OFS_VOLTAGE_MONITOR: rd_w[4:0] = vm_q;
      OFS_STAT: begin
        rd_w[ST_VM_BIT]          = vm_flag_q;
        rd_w[ST_PWR_BIT]         = pwr_flag_q;
        rd_w[ST_MODE_LSB +: 3]   = mode_q;
      end
      OFS_SDC: begin
        rd_w[SD_LOCK_BIT] = lock_q;
        rd_w[SD_WAKE_BIT] = deep_wake_q;
      end
      OFS_CAL:  rd_w[15:0] = cal_q;
      default:  rd_w = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_i.psel && !apb_i.penable) begin
      prdata_q <= rd_w;
    end
  end

  // ====================================================================
  // checks
  sequence s_supply_bad;
    supply_domain_reset_ind_i || core_supply_supervisor_i;
  endsequence

  sequence s_release;
    (state_q == ST_DELAY) && (cnt_q == 16'(REL_CYC - 1));
  endsequence

  a_bor_supply_hold: assert property ( // [RULE1] [RULE3] [RULE5]
    (state_q != ST_OFF) and s_supply_bad |=> brownout_reset_o ##1 brownout_reset_o)
    else $error("brownout reset not held while supply is bad");

  a_bor_release_dly: assert property ( // [RULE2]
    $fell(brownout_reset_o) |-> $past(state_q == ST_DELAY && cnt_q == 16'(REL_CYC - 1)))
    else $error("brownout reset released before the fixed delay");

  a_bor_release_go: assert property ( // [RULE2]
    s_release and (!supply_domain_reset_ind_i && !core_supply_supervisor_i)
      |=> !brownout_reset_o && state_q == ST_RUN)
    else $error("brownout reset not released after the delay");

  a_voltage_monitor_boot_off: assert property ( // [RULE7]
    bor_q |=> !vm_q[VM_EN_BIT] && !voltage_monitor_irq_o)
    else $error("voltage monitor active during brownout reset");

  a_voltage_monitor_irq_raise: assert property ( // [RULE6]
    !bor_q && vm_q[VM_EN_BIT] && vm_low_w && !$past(bor_q)
      |=> voltage_monitor_irq_o || bor_q || $changed(vm_q))
    else $error("voltage monitor low not raising interrupt");

  a_ext_bypass_osc: assert property ( // [RULE8]
    ext_clk_sel_o |-> !osc_enable_o)
    else $error("oscillator enabled while external clock selected");

  a_off_reg_down: assert property ( // [RULE14]
    state_q == ST_OFF |-> !core_regulator_en_o && brownout_reset_o && clk_en_o == '0)
    else $error("core regulator on in deep shutdown");

  a_off_exit_bor: assert property ( // [RULE15] [RULE16]
    off_exit_w |=> state_q == ST_HOLD && brownout_reset_o && deep_wake_q)
    else $error("deep shutdown exit without brownout reset");

  a_pin_lock_hold: assert property ( // [RULE17]
    lock_q |=> $stable(pad_dir_o) && $stable(pad_out_o))
    else $error("pads moved while pin lock set");

  a_pwr_flag_set: assert property ( // [RULE22]
    supply_domain_reset_ind_i |=> pwr_flag_q && cal_q == CAL_RST)
    else $error("power cycle did not set flag and clear calibration");
endmodule

// [inc/cpm_pkg.sv]
// constants, types and field layout of the clock, power and mode control
// assumes one 125 MHz system clock and an apb master with 32-bit data
// Behaviour
// RULE1 - hold brownout reset until core supply usable
// RULE2 - release brownout reset after fixed delay
// RULE3 - later brown-out reasserts reset until supply good
// RULE4 - supply domain indication is active high
// RULE5 - core supervisor indication is active high
// RULE6 - monitor selected voltage, interrupt when below limit
// RULE7 - voltage monitor disabled until firmware enables it
// RULE8 - one source, external input bypasses oscillator
// RULE9 - fixed divide by 512 and by 16
// RULE10 - cpu and sub clocks have own dividers
// RULE11 - power-of-two ratios, change on clean boundary
// RULE12 - low-power modes zero to four plus shutdown
// RULE13 - wake latencies 1 us, 35 us, 0.75 ms
// RULE14 - deep shutdown switches core regulator off
// RULE15 - shutdown exit by pin low, power, wake pin
// RULE16 - shutdown exit gives brownout reset, vector 0xFFFE
// RULE17 - pin lock holds pad direction and output
// RULE18 - firmware programs pins first after reset
// RULE19 - firmware clears pin lock after shutdown wake
// RULE20 - firmware clears pin flags on normal start
// RULE21 - firmware enables pin interrupts last
// RULE22 - power flag and calibration tied to power cycle
package cpm_pkg;

  // ====================================================================
  // timing
  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned AUX_DIV         = 512;
  localparam int unsigned MOD_DIV         = 16;
  localparam int unsigned BOR_RELEASE_NS  = 10000;
  localparam int unsigned REL_CYC         = (BOR_RELEASE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BOR_WAKE_MAX_NS = 750000;
  localparam int unsigned WAKE_MAX_CYC    = BOR_WAKE_MAX_NS * CLK_MHZ / 1000;
  localparam int unsigned LPM3_WAKE_NS    = 1000;
  localparam int unsigned LPM3_WAKE_CYC   = LPM3_WAKE_NS * CLK_MHZ / 1000;
  localparam int unsigned LPM4_WAKE_NS    = 35000;
  localparam int unsigned LPM4_WAKE_CYC   = LPM4_WAKE_NS * CLK_MHZ / 1000;

  // ====================================================================
  // register map
  localparam logic [11:0] OFS_CLK  = 12'h000;
  localparam logic [11:0] OFS_VOLTAGE_MONITOR = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_LPM  = 12'h00C;
  localparam logic [11:0] OFS_SDC  = 12'h010;
  localparam logic [11:0] OFS_CAL  = 12'h014;

  localparam int unsigned CLK_EXT_BIT = 0;
  localparam int unsigned CPU_DIV_LSB = 1;
  localparam int unsigned SUB_DIV_LSB = 4;
  localparam int unsigned VM_EN_BIT   = 0;
  localparam int unsigned VM_SRC_BIT  = 1;
  localparam int unsigned VM_LVL_LSB  = 2;
  localparam int unsigned ST_VM_BIT   = 0;
  localparam int unsigned ST_PWR_BIT  = 1;
  localparam int unsigned ST_MODE_LSB = 2;
  localparam int unsigned SD_LOCK_BIT = 0;
  localparam int unsigned SD_WAKE_BIT = 1;

  localparam logic [6:0]  CLK_RST  = 7'h00;
  localparam logic [4:0]  VM_RST   = 5'h00;
  localparam logic [15:0] CAL_RST  = 16'h0000;
  localparam logic [2:0]  MODE_LPM2 = 3'h2;
  localparam logic [2:0]  MODE_LPM3 = 3'h3;
  localparam logic [2:0]  MODE_LPM4 = 3'h4;
  localparam logic [2:0]  MODE_DEEP = 3'h5;
  localparam logic [15:0] RESET_VECTOR = 16'hFFFE;

  // ====================================================================
  // types
  typedef enum logic [5:0] {
    ST_HOLD  = 6'h01,
    ST_DELAY = 6'h02,
    ST_RUN   = 6'h04,
    ST_LPM   = 6'h08,
    ST_WAKE  = 6'h10,
    ST_OFF   = 6'h20
  } cpm_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cpm_apb_req_t;

  typedef struct packed {
    logic cpu;
    logic sub;
    logic aux;
    logic mdm;
  } cpm_clk_en_t;

endpackage

// [verif/cpm_supply_model.sv]
// partner: supply domain and core supervisor indications, active high
// assumes one system clock; the dip inputs are one-cycle bench commands
module cpm_supply_model (
  input  wire logic clk_i,
  input  wire logic reg_on_i,
  input  wire logic core_dip_i,
  input  wire logic pwr_dip_i,
  output logic      supply_ind_o,
  output logic      core_sup_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int sc = 20;
  int cc = 50;
  // ====================
  // ramp: supply domain settles first, core follows the regulator
  always @(posedge clk_i) begin
    if (pwr_dip_i) begin
      sc <= 20;
      cc <= 50;
    end else if (core_dip_i || !reg_on_i) begin
      cc <= 30;
    end else begin
      sc <= (sc > 0) ? sc - 1 : 0;
      cc <= (sc > 0 || cc == 0) ? cc : cc - 1;
    end
  end
  assign supply_ind_o = (sc != 0);
  assign core_sup_o   = (cc != 0);
endmodule

// [verif/cpm_top_tb_top.sv]
// testbench of the clock, power and mode control
// assumes the supply model as far side and a zero-wait apb slave
module cpm_top_tb_top
  import cpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LW = 10;
  logic clk = 0, rst_n = 0, mon = 0, nmi = 1, wake = 0, cdip = 0, pdip = 0;
  logic dsl = 0, wpi = 0;
  logic [7:0] pdir = '0, pout = '0, pad, old, oo, po;
  cpm_apb_req_t ap = '0;
  logic [31:0] prdata, rd, c, seed = 32'h0000_0037;
  logic pready, perr, se, bor, reg_on, ind, sup, irq, ext, osc;
  logic [3:0] ce;
  logic [2:0] lvl, mode, s, s2;
  logic [15:0] vec;
  int miscompares = 0, checks = 0, n, e;

  cpm_supply_model cpm_supply_model_i (.clk_i(clk), .reg_on_i(reg_on),
    .core_dip_i(cdip), .pwr_dip_i(pdip), .supply_ind_o(ind), .core_sup_o(sup));
  cpm_top #(.LPM4_WAKE(LW)) cpm_top_i (.sys_clk_i(clk), .rst_n_i(rst_n), .apb_i(ap),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .supply_domain_reset_ind_i(ind), .core_supply_supervisor_i(sup),
    .monitor_input_pin_low_i(mon), .digital_supply_low_i(dsl), .nmi_pin_n_i(nmi),
    .wake_pin_irq_i(wpi), .wake_event_i(wake), .pin_direction_i(pdir),
    .pin_output_i(pout), .brownout_reset_o(bor), .core_regulator_en_o(reg_on),
    .osc_enable_o(osc), .ext_clk_sel_o(ext), .clk_en_o(ce),
    .voltage_monitor_level_o(lvl), .voltage_monitor_irq_o(irq),
    .reset_vector_o(vec), .lpm_mode_o(mode), .pad_dir_o(pad), .pad_out_o(po));

  always #4 clk = ~clk;

  // ====================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] sn, input logic [31:0] ex);
    checks++;
    if (sn !== ex) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, sn, ex);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    ap <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    ap.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    se = perr;
    ap <= '0;
  endtask
  task automatic waitlow(output int k);
    k = 0;
    while (bor !== 1'b0 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 5000) begin
      miscompares++;
    end
  endtask
  // skip two periods so a ratio change has landed before measuring
  task automatic gap(input int b, output int k);
    repeat (3) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (ce[b] !== 1'b1 && k < 600);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    miscompares++;
    report_and_stop;
  end

  // ====================
  // tests
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    while (sup !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(n < 200, 1);
    chk(bor, 1);
    waitlow(n);
    chk(n >= REL_CYC && n <= REL_CYC + 3, 1);
    apb(0, OFS_CLK, 0);
    chk(rd, CLK_RST);
    apb(0, OFS_VOLTAGE_MONITOR, 0);
    chk(rd, VM_RST);
    apb(0, 12'h0FC, 0);
    chk(se, 1);
    chk(rd, 0);
    $display("test registers done");
    mon <= 1'b1;
    repeat (3) @(posedge clk);
    chk(irq, 0);
    s = 3'(rnd());
    apb(1, OFS_VOLTAGE_MONITOR, {s, 1'b0, 1'b1});
    repeat (2) @(posedge clk);
    chk(lvl, s);
    chk(irq, 1);
    mon <= 1'b0;
    apb(1, OFS_STAT, 1);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    dsl <= 1'b1;
    apb(1, OFS_VOLTAGE_MONITOR, {s, 1'b1, 1'b1});
    repeat (2) @(posedge clk);
    chk(irq, 1);
    $display("test monitor done");
    for (int i = 0; i < 4; i++) begin
      s = (i == 0) ? 3'h0 : (i == 3) ? 3'h7 : 3'(rnd());
      s2 = 3'(rnd());
      apb(1, OFS_CLK, {s2, s, 1'b1});
      gap(3, n);
      chk(ext, 1);
      chk(osc, 0);
      chk(n, 1 << s);
      gap(2, n);
      chk(n, 1 << s2);
    end
    gap(1, n);
    chk(n, AUX_DIV);
    gap(0, n);
    chk(n, MOD_DIV);
    apb(1, OFS_CLK, 0);
    gap(3, n);
    chk(n, 1);
    chk(osc, 1);
    $display("test dividers done");
    for (int m = 0; m < 5; m++) begin
      apb(1, OFS_LPM, m);
      wake <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (ce[3] !== 1'b1 && n < 300);
      wake <= 1'b0;
      chk(mode, m);
      e = (m == 3) ? LPM3_WAKE_CYC : (m == 4) ? LW : 1;
      chk(n >= e && n <= e + 3, 1);
    end
    $display("test modes done");
    c = rnd();
    apb(1, OFS_CAL, c[15:0]);
    apb(0, OFS_STAT, 0);
    chk(rd[1], 1);
    apb(1, OFS_STAT, 2);
    cdip <= 1'b1;
    @(posedge clk);
    cdip <= 1'b0;
    repeat (2) @(posedge clk);
    chk(bor, 1);
    waitlow(n);
    chk(n <= WAKE_MAX_CYC, 1);
    apb(0, OFS_STAT, 0);
    chk(rd[1], 0);
    apb(0, OFS_CAL, 0);
    chk(rd, c[15:0]);
    $display("test brownout done");
    pdir <= 8'(rnd());
    pout <= 8'(rnd());
    repeat (2) @(posedge clk);
    old = pdir;
    oo = pout;
    apb(1, OFS_LPM, 5);
    @(posedge clk);
    chk(reg_on, 0);
    chk(bor, 1);
    pdir <= ~old; // pins reprogrammed before unlock
    pout <= ~oo;
    repeat (3) @(posedge clk);
    chk(pad, old);
    chk(po, oo);
    nmi <= 1'b0;
    @(posedge clk);
    nmi <= 1'b1;
    repeat (2) @(posedge clk);
    waitlow(n);
    chk(reg_on, 1);
    chk(vec, 16'hFFFE);
    chk(pad, old);
    chk(po, oo);
    apb(0, OFS_SDC, 0);
    chk(rd[1:0], 2'b11);
    apb(1, OFS_SDC, 2);
    repeat (2) @(posedge clk);
    chk(pad, 8'(~old));
    chk(po, 8'(~oo));
    wpi <= 1'b0; // pin flags clear before interrupts are enabled
    apb(1, OFS_LPM, 5);
    wpi <= 1'b1; // wake-capable pin fires
    @(posedge clk);
    wpi <= 1'b0;
    waitlow(n);
    apb(0, OFS_SDC, 0);
    chk(rd[1:0], 2'b11);
    $display("test shutdown done");
    pdip <= 1'b1;
    @(posedge clk);
    pdip <= 1'b0;
    repeat (2) @(posedge clk);
    waitlow(n);
    apb(0, OFS_CAL, 0);
    chk(rd, CAL_RST);
    apb(0, OFS_STAT, 0);
    chk(rd[1], 1);
    $display("test power cycle done");
    report_and_stop;
  end
endmodule
